// File: inc/art_pwm_pkg.sv
// Package for the auto-reload PWM timer: register map, field layout, reset values.
// Assumes a 32-bit AXI4-Lite register bus; each register takes one aligned word.
package art_pwm_pkg;
   // Printed offsets are indices (not multiples of four); byte address = 4 * index
   localparam logic [7:0] IDX_DUTY_CH3    = 8'h72;
   localparam logic [7:0] IDX_DUTY_CH2    = 8'h73;
   localparam logic [7:0] IDX_DUTY_CH1    = 8'h74;
   localparam logic [7:0] IDX_DUTY_CH0    = 8'h75;
   localparam logic [7:0] IDX_PWM_CTRL    = 8'h76;
   localparam logic [7:0] IDX_TIMER_CSR   = 8'h77;
   localparam logic [7:0] IDX_LIVE_COUNT  = 8'h78;
   localparam logic [7:0] IDX_RELOAD      = 8'h79;
   localparam logic [7:0] IDX_IRQ_STATUS  = 8'h7a;
   localparam logic [7:0] IDX_IRQ_MASK    = 8'h7b;
   localparam int         ADDR_W          = 12;
   localparam int         IDX_LSB         = 2;
   localparam int         NUM_CH          = 4;
   localparam int         PRESC_W         = 7;
   // Control/status fields
   localparam int         CSR_EXT_CLK     = 7;
   localparam int         CSR_PRESC_HI    = 6;
   localparam int         CSR_PRESC_LO    = 4;
   localparam int         CSR_RUN         = 3;
   localparam int         CSR_FORCE       = 2;
   localparam int         CSR_OVF_IE      = 1;
   localparam int         CSR_OVF         = 0;
   // Output control fields
   localparam int         CTRL_OE_LSB     = 4;
   localparam int         CTRL_POL_LSB    = 0;
   localparam logic [7:0] REG_RESET       = 8'h00;
   localparam logic [7:0] COUNT_MAX       = 8'hff;
   localparam logic [1:0] RESP_OKAY       = 2'h0;
   localparam logic [1:0] RESP_SLVERR     = 2'h2;
endpackage

// File: hdl/art_prescaler.sv
// Power-of-two prescaler producing a one-cycle counter tick enable.
// Assumes the input event is already synchronous to clock_i.
`timescale 1ns/1ps
`default_nettype none
module art_prescaler #(
   parameter int WIDTH = 7
) (
   // Clock and reset
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   // Control
   input  wire logic       event_i,
   input  wire logic       run_i,
   input  wire logic       clear_i,
   input  wire logic [2:0] select_i,
   // Tick
   output logic            tick_o
);
   logic [WIDTH-1:0] count_q;
   logic [WIDTH:0]   full;

   // Extended count lets tap n fire when the low n bits are all ones
   assign full = {1'b0, count_q};

   always_ff @(posedge clock_i) begin
      if (rst_i || clear_i) begin
         count_q <= '0;
      end else if (run_i && event_i) begin
         count_q <= count_q + 1'b1;
      end
   end

   always_comb begin
      tick_o = 1'b0;
      if (run_i && event_i) begin
         tick_o = (select_i == 3'h0) ? 1'b1 : &(full | ~((({{WIDTH{1'b0}}, 1'b1}) << select_i) - 1'b1));
      end
   end
endmodule
`default_nettype wire

// File: hdl/art_pwm_timer.sv
// Auto-reload 8-bit PWM timer with four channels behind an AXI4-Lite slave.
// Assumes EXT_CLK_I is an asynchronous event pin, at most a quarter of the clock rate.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module art_pwm_timer
   import art_pwm_pkg::*;
(
   // Clock and reset
   input  wire logic                       CLOCK_I,
   input  wire logic                       RST_I,
   // AXI4-Lite write address
   input  wire logic                       AWVALID_I,
   output logic                            AWREADY_O,
   input  wire logic [art_pwm_pkg::ADDR_W-1:0] AWADDR_I,
   // AXI4-Lite write data
   input  wire logic                       WVALID_I,
   output logic                            WREADY_O,
   input  wire logic [31:0]                WDATA_I,
   input  wire logic [3:0]                 WSTRB_I,
   // AXI4-Lite write response
   output logic                            BVALID_O,
   input  wire logic                       BREADY_I,
   output logic [1:0]                      BRESP_O,
   // AXI4-Lite read address
   input  wire logic                       ARVALID_I,
   output logic                            ARREADY_O,
   input  wire logic [art_pwm_pkg::ADDR_W-1:0] ARADDR_I,
   // AXI4-Lite read data
   output logic                            RVALID_O,
   input  wire logic                       RREADY_I,
   output logic [31:0]                     RDATA_O,
   output logic [1:0]                      RRESP_O,
   // External clock pin
   input  wire logic                       EXT_CLK_I,
   // PWM pins
   output logic [art_pwm_pkg::NUM_CH-1:0]  PWM_CHANNEL_PIN_O,
   output logic [art_pwm_pkg::NUM_CH-1:0]  PWM_CHANNEL_PIN_OE_N_O,
   // Interrupt
   output logic                            IRQ_O
);

   //////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [7:0]        duty_value_bits_q [NUM_CH];
   logic [7:0]        hidden_compare_value_q [NUM_CH];
   logic [7:0]        pwm_output_control_q;
   logic [7:0]        counter_value_bits_q;
   logic [7:0]        reload_bits_q;
   logic              external_clock_select_q;
   logic [2:0]        prescale_select_q;
   logic              counter_run_enable_q;
   logic              overflow_irq_enable_q;
   logic              overflow_flag_q;
   logic              irq_status_q;
   logic              irq_mask_q;
   logic [NUM_CH-1:0] wave_q;

   //////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave

   logic                aw_full_q;
   logic                w_full_q;
   logic [7:0]          aw_idx_q;
   logic [31:0]         wdata_q;
   logic [3:0]          wstrb_q;
   logic                wr_fire;
   logic                wr_byte;
   logic                rd_fire;
   logic [7:0]          ar_idx;
   logic [7:0]          rd_byte;
   logic                rd_hit;
   logic                wr_hit;

   assign wr_fire = aw_full_q && w_full_q && !BVALID_O;
   assign wr_byte = wstrb_q[0];
   assign ar_idx  = ARADDR_I[IDX_LSB +: 8];
   assign rd_fire = ARVALID_I && ARREADY_O;

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         aw_full_q <= 1'b0;
         aw_idx_q  <= 8'h00;
         AWREADY_O <= 1'b0;
      end else if (AWVALID_I && AWREADY_O) begin
         aw_full_q <= 1'b1;
         aw_idx_q  <= AWADDR_I[IDX_LSB +: 8];
         AWREADY_O <= 1'b0;
      end else if (wr_fire) begin
         aw_full_q <= 1'b0;
      end else begin
         AWREADY_O <= !aw_full_q && !BVALID_O;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         w_full_q <= 1'b0;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
         WREADY_O <= 1'b0;
      end else if (WVALID_I && WREADY_O) begin
         w_full_q <= 1'b1;
         wdata_q  <= WDATA_I;
         wstrb_q  <= WSTRB_I;
         WREADY_O <= 1'b0;
      end else if (wr_fire) begin
         w_full_q <= 1'b0;
      end else begin
         WREADY_O <= !w_full_q && !BVALID_O;
      end
   end

   always_comb begin
      unique case (aw_idx_q)
         IDX_DUTY_CH3, IDX_DUTY_CH2, IDX_DUTY_CH1, IDX_DUTY_CH0, IDX_PWM_CTRL, IDX_TIMER_CSR,
         IDX_LIVE_COUNT, IDX_RELOAD, IDX_IRQ_STATUS, IDX_IRQ_MASK: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         BVALID_O <= 1'b0;
         BRESP_O  <= RESP_OKAY;
      end else if (wr_fire) begin
         BVALID_O <= 1'b1;
         BRESP_O  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (BREADY_I) begin
         BVALID_O <= 1'b0;
      end
   end

   // Write strobes, only for the low byte lane where the 8-bit registers sit
   logic w_ctrl;
   logic w_csr;
   logic w_count;
   logic w_reload;
   logic w_status;
   logic w_mask;
   logic force_reload;

   assign w_ctrl       = wr_fire && wr_byte && aw_idx_q == IDX_PWM_CTRL;
   assign w_csr        = wr_fire && wr_byte && aw_idx_q == IDX_TIMER_CSR;
   assign w_count      = wr_fire && wr_byte && aw_idx_q == IDX_LIVE_COUNT;
   assign w_reload     = wr_fire && wr_byte && aw_idx_q == IDX_RELOAD;
   assign w_status     = wr_fire && wr_byte && aw_idx_q == IDX_IRQ_STATUS;
   assign w_mask       = wr_fire && wr_byte && aw_idx_q == IDX_IRQ_MASK;
   assign force_reload = w_csr && wdata_q[CSR_FORCE];

   always_comb begin
      rd_hit  = 1'b1;
      rd_byte = 8'h00;
      unique case (ar_idx)
         IDX_DUTY_CH3:   rd_byte = duty_value_bits_q[3];
         IDX_DUTY_CH2:   rd_byte = duty_value_bits_q[2];
         IDX_DUTY_CH1:   rd_byte = duty_value_bits_q[1];
         IDX_DUTY_CH0:   rd_byte = duty_value_bits_q[0];
         IDX_PWM_CTRL:   rd_byte = pwm_output_control_q;
         // Force-reload always reads as zero
         IDX_TIMER_CSR:  rd_byte = {external_clock_select_q, prescale_select_q, counter_run_enable_q,
                                    1'b0, overflow_irq_enable_q, overflow_flag_q};
         IDX_LIVE_COUNT: rd_byte = counter_value_bits_q;
         IDX_RELOAD:     rd_byte = reload_bits_q;
         IDX_IRQ_STATUS: rd_byte = {7'h00, irq_status_q};
         IDX_IRQ_MASK:   rd_byte = {7'h00, irq_mask_q};
         default: begin
            rd_hit  = 1'b0;
            rd_byte = 8'h00;
         end
      endcase
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         ARREADY_O <= 1'b0;
         RVALID_O  <= 1'b0;
         RDATA_O   <= 32'h0000_0000;
         RRESP_O   <= RESP_OKAY;
      end else if (rd_fire) begin
         ARREADY_O <= 1'b0;
         RVALID_O  <= 1'b1;
         RDATA_O   <= {24'h00_0000, rd_byte};
         RRESP_O   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (RVALID_O) begin
         if (RREADY_I) begin
            RVALID_O <= 1'b0;
         end
      end else begin
         ARREADY_O <= 1'b1;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // External clock pin: three stages, an edge counts when stages two and three agree

   logic [2:0] ext_sync_q;
   logic       ext_level_q;
   logic       ext_rise;
   logic       tick;

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         ext_sync_q  <= 3'h0;
         ext_level_q <= 1'b0;
      end else begin
         ext_sync_q <= {ext_sync_q[1:0], EXT_CLK_I};
         if (ext_sync_q[1] == ext_sync_q[2]) begin
            ext_level_q <= ext_sync_q[2];
         end
      end
   end

   assign ext_rise = ext_sync_q[1] && ext_sync_q[2] && !ext_level_q;

   // Counter write also clears the prescaler so counting starts from a known point
   art_prescaler #(
      .WIDTH (PRESC_W)
   ) u_prescaler (
      .clock_i  (CLOCK_I),
      .rst_i    (RST_I),
      .event_i  (external_clock_select_q ? ext_rise : 1'b1),
      .run_i    (counter_run_enable_q),
      .clear_i  (force_reload || w_count),
      .select_i (prescale_select_q),
      .tick_o   (tick)
   );

   //////////////////////////////////////////////////////////////////////////////
   // Counter

   logic overflow;

   assign overflow = tick && counter_value_bits_q == COUNT_MAX;

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         counter_value_bits_q <= REG_RESET;
      end else if (w_count) begin
         counter_value_bits_q <= wdata_q[7:0];
      end else if (force_reload) begin
         counter_value_bits_q <= reload_bits_q;
      end else if (overflow) begin
         counter_value_bits_q <= reload_bits_q;
      end else if (tick) begin
         counter_value_bits_q <= counter_value_bits_q + 8'h01;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         reload_bits_q        <= REG_RESET;
         pwm_output_control_q <= REG_RESET;
      end else begin
         if (w_reload) begin
            reload_bits_q <= wdata_q[7:0];
         end
         if (w_ctrl) begin
            pwm_output_control_q <= wdata_q[7:0];
         end
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         external_clock_select_q <= 1'b0;
         prescale_select_q       <= 3'h0;
         counter_run_enable_q    <= 1'b0;
         overflow_irq_enable_q   <= 1'b0;
      end else if (w_csr) begin
         external_clock_select_q <= wdata_q[CSR_EXT_CLK];
         prescale_select_q       <= wdata_q[CSR_PRESC_HI:CSR_PRESC_LO];
         counter_run_enable_q    <= wdata_q[CSR_RUN];
         overflow_irq_enable_q   <= wdata_q[CSR_OVF_IE];
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Overflow flag and interrupt status; a new overflow wins over the clear

   logic csr_read;

   assign csr_read = rd_fire && ar_idx == IDX_TIMER_CSR;

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         overflow_flag_q <= 1'b0;
      end else if (overflow) begin
         overflow_flag_q <= 1'b1;
      end else if (csr_read) begin
         overflow_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         irq_status_q <= 1'b0;
         irq_mask_q   <= 1'b0;
      end else begin
         if (overflow && overflow_irq_enable_q) begin
            irq_status_q <= 1'b1;
         end else if (w_status && wdata_q[0]) begin
            irq_status_q <= 1'b0;
         end
         if (w_mask) begin
            irq_mask_q <= wdata_q[0];
         end
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         IRQ_O <= 1'b0;
      end else begin
         IRQ_O <= irq_status_q && irq_mask_q;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Channels

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         localparam logic [7:0] DUTY_IDX = IDX_DUTY_CH0 - 8'(ch);
         logic pol;
         logic level;
         assign pol   = pwm_output_control_q[CTRL_POL_LSB + ch];
         // Raw waveform is high from reload until the count passes compare
         assign level = wave_q[ch] ^ pol;

         always_ff @(posedge CLOCK_I) begin
            if (RST_I) begin
               duty_value_bits_q[ch]      <= REG_RESET;
               hidden_compare_value_q[ch] <= REG_RESET;
            end else begin
               if (wr_fire && wr_byte && aw_idx_q == DUTY_IDX) begin
                  duty_value_bits_q[ch] <= wdata_q[7:0];
               end
               if (overflow) begin
                  hidden_compare_value_q[ch] <= duty_value_bits_q[ch];
               end
            end
         end

         // Waveform state advances regardless of the enable
         always_ff @(posedge CLOCK_I) begin
            if (RST_I) begin
               wave_q[ch] <= 1'b1;
            end else if (overflow) begin
               wave_q[ch] <= 1'b1;
            end else if (tick && counter_value_bits_q + 8'h01 > hidden_compare_value_q[ch]) begin
               wave_q[ch] <= 1'b0;
            end
         end

         always_ff @(posedge CLOCK_I) begin
            if (RST_I) begin
               PWM_CHANNEL_PIN_O[ch]      <= 1'b0;
               PWM_CHANNEL_PIN_OE_N_O[ch] <= 1'b1;
            end else begin
               PWM_CHANNEL_PIN_O[ch]      <= level;
               PWM_CHANNEL_PIN_OE_N_O[ch] <= !pwm_output_control_q[CTRL_OE_LSB + ch];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// File: testbench/auto_reload_pwm_timer_assertions.sv
// Checker for the auto-reload PWM timer, watching only the top module's ports.
// Assumes one clock domain and the synchronous active-high reset of the top module.
`timescale 1ns/1ps
`default_nettype none
module auto_reload_pwm_timer_assertions
   import art_pwm_pkg::*;
(
   input wire logic                    CLOCK_I,
   input wire logic                    RST_I,
   input wire logic                    AWVALID_I,
   input wire logic                    AWREADY_O,
   input wire logic                    WVALID_I,
   input wire logic                    WREADY_O,
   input wire logic                    BVALID_O,
   input wire logic                    ARVALID_I,
   input wire logic                    ARREADY_O,
   input wire logic [ADDR_W-1:0]       ARADDR_I,
   input wire logic                    RVALID_O,
   input wire logic                    RREADY_I,
   input wire logic [31:0]             RDATA_O,
   input wire logic [NUM_CH-1:0]       PWM_CHANNEL_PIN_OE_N_O,
   input wire logic                    IRQ_O
);
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);

   sequence write_taken;
      AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
   endsequence
   sequence status_read;
      ARVALID_I && ARREADY_O && ARADDR_I == {2'b00, IDX_TIMER_CSR, 2'b00};
   endsequence

   ////////////////////////////////////////////////////////////////////////////////
   reset_clears_all_a: assert property ($fell(RST_I) |->
      PWM_CHANNEL_PIN_OE_N_O == 4'hf && !IRQ_O && !BVALID_O && !RVALID_O) else $error("state not cleared by reset");
   read_answers_a: assert property (ARVALID_I && ARREADY_O |=> RVALID_O) else $error("read not answered");
   write_answers_a: assert property (write_taken |-> ##2 BVALID_O) else $error("write not answered");
   force_reads_zero_a: assert property (status_read |=> RVALID_O && !RDATA_O[CSR_FORCE])
      else $error("force reload bit read back as one");
   read_byte_wide_a: assert property (RVALID_O |-> RDATA_O[31:8] == 24'h0) else $error("upper read bits set");
   read_data_held_a: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
      else $error("read data dropped before taken");
   busy_refuses_write_a: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
      else $error("write accepted while one is pending");
   enable_by_write_a: assert property ($changed(PWM_CHANNEL_PIN_OE_N_O) |->
      $past(BVALID_O) || $past(BVALID_O, 2)) else $error("pin enable changed without a write");
   irq_clear_write_a: assert property ($fell(IRQ_O) |-> $past(BVALID_O) || $past(BVALID_O, 2))
      else $error("interrupt dropped without a write");
endmodule

bind art_pwm_timer auto_reload_pwm_timer_assertions i_checker (.*);
`default_nettype wire

// File: testbench/auto_reload_pwm_timer_test.sv
// Self-checking testbench for the auto-reload PWM timer, driving AXI4-Lite itself.
// Assumes the register map of art_pwm_pkg and a 125 MHz clock; the bench toggles the external clock pin.
`timescale 1ns/1ps
`default_nettype none
module auto_reload_pwm_timer_test;
   import art_pwm_pkg::*;
   logic CLOCK_I = 0, RST_I = 1, AWVALID_I = 0, WVALID_I = 0, BREADY_I = 0, ARVALID_I = 0, RREADY_I = 0;
   logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, IRQ_O, EXT_CLK_I = 0;
   logic [ADDR_W-1:0] AWADDR_I = '0, ARADDR_I = '0;
   logic [31:0]       WDATA_I = '0, RDATA_O, rdat, a, n;
   logic [3:0]        WSTRB_I = '0, PWM_CHANNEL_PIN_O, PWM_CHANNEL_PIN_OE_N_O, p;
   logic [1:0]        BRESP_O, RRESP_O, wrsp, rrsp;
   int                fails = 0, checks = 0, cyc = 0, rcyc, t1, k, c;
   int                hi [4];

   art_pwm_timer i_dut (.*);

   always #4 CLOCK_I = ~CLOCK_I;
   always @(posedge CLOCK_I) cyc <= cyc + 1;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Address and data are offered together; each is released once taken
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      int i;
      @(posedge CLOCK_I);
      AWADDR_I  <= {2'b00, idx, 2'b00};
      WDATA_I   <= {24'h0, d};
      WSTRB_I   <= 4'h1;
      AWVALID_I <= 1'b1;
      WVALID_I  <= 1'b1;
      BREADY_I  <= 1'b1;
      for (i = 0; i < 60; i++) begin
         @(posedge CLOCK_I);
         if (AWVALID_I && AWREADY_O) AWVALID_I <= 1'b0;
         if (WVALID_I && WREADY_O) WVALID_I <= 1'b0;
         if (BVALID_O) begin
            wrsp = BRESP_O;
            BREADY_I <= 1'b0;
            break;
         end
      end
      if (i == 60) chk(32'h1, 32'h0);
   endtask

   // Records the cycle of the address handshake, where the data is sampled
   task automatic rd(input logic [7:0] idx);
      int i;
      @(posedge CLOCK_I);
      ARADDR_I  <= {2'b00, idx, 2'b00};
      ARVALID_I <= 1'b1;
      RREADY_I  <= 1'b1;
      for (i = 0; i < 60; i++) begin
         @(posedge CLOCK_I);
         if (ARVALID_I && ARREADY_O) begin
            ARVALID_I <= 1'b0;
            rcyc = cyc;
         end
         if (RVALID_O) begin
            rdat = RDATA_O;
            rrsp = RRESP_O;
            RREADY_I <= 1'b0;
            break;
         end
      end
      if (i == 60) chk(32'h1, 32'h0);
   endtask

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (60000) @(posedge CLOCK_I);
      fails++;
      $display("Error %0t: watchdog expired", $time);
      complete_run;
   end

   initial begin
      repeat (12) @(posedge CLOCK_I);
      RST_I <= 1'b0;
      for (k = 8'h72; k <= 8'h7b; k++) begin
         rd(8'(k));
         chk(rdat, 32'h0);
      end
      chk(32'(PWM_CHANNEL_PIN_OE_N_O), 32'hf);
      rd(8'h10);
      chk({rdat[29:0], rrsp}, 32'(RESP_SLVERR));
      wr(8'h10, 8'h55);
      chk(32'(wrsp), 32'(RESP_SLVERR));
      for (k = 8'h72; k <= 8'h76; k++) begin
         wr(8'(k), 8'(k + 8'h11));
         rd(8'(k));
         chk(rdat, 32'(8'(k + 8'h11)));
      end
      $display("Test of reset values and access done");

      // Counter port, force reload and freeze
      wr(IDX_RELOAD, 8'h80);
      wr(IDX_TIMER_CSR, 8'h04);
      rd(IDX_LIVE_COUNT);
      chk(rdat, 32'h80);
      rd(IDX_TIMER_CSR);
      chk(rdat, 32'h0);
      wr(IDX_LIVE_COUNT, 8'h10);
      rd(IDX_LIVE_COUNT);
      chk(rdat, 32'h10);
      wr(IDX_TIMER_CSR, 8'h08);
      rd(IDX_LIVE_COUNT);
      a = rdat;
      t1 = rcyc;
      wr(IDX_LIVE_COUNT, 8'h30);
      rd(IDX_LIVE_COUNT);
      chk(32'(rdat > 8'h30 && rdat < 8'h40 && a < 8'h20), 32'h1);
      wr(IDX_TIMER_CSR, 8'h00);
      rd(IDX_LIVE_COUNT);
      a = rdat;
      repeat (20) @(posedge CLOCK_I);
      rd(IDX_LIVE_COUNT);
      chk(rdat, a);
      // One tick of divide-by-128 from FFh must land on the reload value
      wr(IDX_LIVE_COUNT, 8'hff);
      wr(IDX_TIMER_CSR, 8'h78);
      repeat (150) @(posedge CLOCK_I);
      wr(IDX_TIMER_CSR, 8'h00);
      rd(IDX_LIVE_COUNT);
      chk(rdat, 32'h80);
      $display("Test of counter access done");

      // External pin events, one count per rising edge at an eighth of the clock rate
      wr(IDX_LIVE_COUNT, 8'h40);
      wr(IDX_TIMER_CSR, 8'h88);
      repeat (5) begin
         repeat (4) @(posedge CLOCK_I);
         EXT_CLK_I <= 1'b1;
         repeat (4) @(posedge CLOCK_I);
         EXT_CLK_I <= 1'b0;
      end
      repeat (8) @(posedge CLOCK_I);
      rd(IDX_LIVE_COUNT);
      chk(rdat, 32'h45);
      wr(IDX_TIMER_CSR, 8'h00);
      $display("Test of external clock done");

      // Every prescaler tap: ticks seen over a measured span
      for (k = 0; k < 8; k++) begin
         wr(IDX_TIMER_CSR, 8'h00);
         wr(IDX_LIVE_COUNT, 8'h80);
         wr(IDX_TIMER_CSR, 8'(8'h08 | (k << 4)));
         rd(IDX_LIVE_COUNT);
         a = rdat;
         t1 = rcyc;
         repeat (20 << k) @(posedge CLOCK_I);
         rd(IDX_LIVE_COUNT);
         n = 32'((rcyc - t1) >> k);
         chk(32'((rdat - a) >= n && (rdat - a) <= n + 1), 32'h1);
      end
      $display("Test of prescaler done");

      // Four channels, period 64, channel 3 inverted
      wr(IDX_TIMER_CSR, 8'h00);
      wr(IDX_RELOAD, 8'hc0);
      wr(IDX_DUTY_CH0, 8'hcf);
      wr(IDX_DUTY_CH1, 8'hff);
      wr(IDX_DUTY_CH2, 8'hdf);
      wr(IDX_DUTY_CH3, 8'hc7);
      wr(IDX_PWM_CTRL, 8'hf8);
      wr(IDX_TIMER_CSR, 8'h08);
      repeat (140) @(posedge CLOCK_I);
      hi = '{0, 0, 0, 0};
      repeat (256) begin
         @(posedge CLOCK_I);
         for (c = 0; c < 4; c++) hi[c] += PWM_CHANNEL_PIN_O[c];
      end
      chk(32'(hi[0]), 32'd64);
      chk(32'(hi[1]), 32'd256);
      chk(32'(hi[2]), 32'd128);
      chk(32'(hi[3]), 32'd224);
      wr(IDX_TIMER_CSR, 8'h00);
      repeat (3) @(posedge CLOCK_I);
      p = PWM_CHANNEL_PIN_O;
      wr(IDX_PWM_CTRL, 8'hf9);
      repeat (2) @(posedge CLOCK_I);
      chk(32'(PWM_CHANNEL_PIN_O), 32'(p ^ 4'h1));
      chk(32'(PWM_CHANNEL_PIN_OE_N_O), 32'h0);
      wr(IDX_PWM_CTRL, 8'h59);
      repeat (2) @(posedge CLOCK_I);
      chk(32'(PWM_CHANNEL_PIN_OE_N_O), 32'ha);
      chk(32'(PWM_CHANNEL_PIN_O), 32'(p ^ 4'h1));
      $display("Test of pwm outputs done");

      // Overflow flag clears on read; interrupt raised, cleared and masked
      rd(IDX_TIMER_CSR);
      chk(rdat, 32'h01);
      rd(IDX_TIMER_CSR);
      chk(rdat, 32'h00);
      for (k = 1; k >= 0; k--) begin
         wr(IDX_IRQ_MASK, 8'(k));
         wr(IDX_TIMER_CSR, 8'h0a);
         repeat (80) @(posedge CLOCK_I);
         chk(32'(IRQ_O), 32'(k));
         wr(IDX_TIMER_CSR, 8'h02);
         rd(IDX_IRQ_STATUS);
         chk(rdat, 32'h1);
         wr(IDX_IRQ_STATUS, 8'h01);
         repeat (2) @(posedge CLOCK_I);
         chk(32'(IRQ_O), 32'h0);
         rd(IDX_IRQ_STATUS);
         chk(rdat, 32'h0);
      end
      $display("Test of overflow interrupt done");
      complete_run;
   end
endmodule
`default_nettype wire
